// *** core/rtc_consts.svh ***
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define ADDR_W 8
`define OFF_SEC 8'h00
`define OFF_SSEC 8'h04
`define OFF_DAY 8'h08
`define OFF_RELOAD 8'h0c
`define OFF_CTRL 8'h10
`define OFF_TRIM 8'h14
`define OFF_OSC 8'h18
`define B_UNLOCK 15
`define B_ASYNC 14
`define B_FT_HI 10
`define B_FT_LO 9
`define B_SQE 8
`define B_IFLAG 7
`define B_DFLAG 6
`define B_RDYE 5
`define B_RDY 4
`define B_IEN 2
`define B_DEN 1
`define B_RUN 0
`define B_RAW_OUT 5
`define B_BYPASS 4
`define SSEC_W 12
`define SSEC_MAX 12'hfff
`define DAY_W 20
`define TRIM_W 8
`define OSC_RESET 4'h9
`define VBAT_DIV_MAX 5'h1f
`define READY_TIME_NS 120000
`define CLK_PERIOD_NS 25
`define BUSY_CYCLES 4
`define PRESCALE_W 3
`define TRIM_WINDOW_BITS 20
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** core/rtc_pkg.sv ***
package rtc_pkg;
  typedef enum logic {SYNC_IDLE, SYNC_WAIT} sync_state_type;
  typedef enum logic [1:0] {FREQ_1HZ, FREQ_512HZ, FREQ_4K, FREQ_4K_ALT} freq_sel_type;
endpackage

// *** core/rtc_tick_gen.sv ***
`timescale 1ns/100ps
`include "rtc_consts.svh"
module rtc_tick_gen import rtc_pkg::*; #(
  parameter int WINDOW_BITS = `TRIM_WINDOW_BITS
) (
  input logic aclk,
  input logic aresetn,
  input logic crystal_input_pin,
  input logic run,
  input logic [`TRIM_W-1:0] trim,
  output logic osc_level,
  output logic raw_4k,
  output logic sub_tick
);
  // A window must hold more oscillator ticks than the largest correction
  if (WINDOW_BITS < `TRIM_W + 1) begin : g_check
    $error("rtc_tick_gen: trim window too short");
  end

  logic [2:0] sync_pipe;
  logic osc_prev;
  logic osc_tick;
  logic [`PRESCALE_W-1:0] raw_div;
  logic [`PRESCALE_W-1:0] comp_div;
  logic [`PRESCALE_W:0] comp_sum;
  logic [WINDOW_BITS-1:0] window;
  logic [`TRIM_W-1:0] corr_left;
  logic [1:0] step;

  // Pin sampler; a level counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_pipe <= 3'h0;
      osc_level <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      sync_pipe <= {sync_pipe[1:0], crystal_input_pin};
      if (sync_pipe[1] == sync_pipe[2]) begin
        osc_level <= sync_pipe[2];
      end
      osc_prev <= osc_level;
    end
  end

  assign osc_tick = osc_level && !osc_prev;

  // Free-running divider, unaffected by enable or trim
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_div <= '0;
      raw_4k <= 1'b0;
    end else begin
      if (osc_tick) begin
        raw_div <= raw_div + 3'h1;
      end
      raw_4k <= raw_div[`PRESCALE_W-1];
    end
  end

  // Positive trim inserts a tick, negative swallows one
  always_comb begin
    step = 2'h1;
    if (corr_left != '0) begin
      step = trim[`TRIM_W-1] ? 2'h0 : 2'h2;
    end
  end

  assign comp_sum = {1'b0, comp_div} + {2'h0, step};
  assign sub_tick = run && osc_tick && comp_sum[`PRESCALE_W];

  // Trimmed prescaler stops with the counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_div <= '0;
    end else if (run && osc_tick) begin
      comp_div <= comp_sum[`PRESCALE_W-1:0];
    end
  end

  // About one correction per ppm per window of ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      window <= '0;
      corr_left <= '0;
    end else if (osc_tick) begin
      window <= window + 1'b1;
      if (&window) begin
        corr_left <= trim[`TRIM_W-1] ? (~trim + 8'h1) : trim;
      end else if (run && corr_left != '0) begin
        corr_left <= corr_left - 8'h1;
      end
    end
  end
endmodule

// *** core/rtc_alarm_squarewave_trim.sv ***
`timescale 1ns/100ps
`include "rtc_consts.svh"
module rtc_alarm_squarewave_trim import rtc_pkg::*; #(
  parameter int READY_CYCLES = `READY_TIME_NS / `CLK_PERIOD_NS,
  parameter int BUSY_CYCLES = `BUSY_CYCLES
) (
  input logic aclk,
  input logic aresetn,
  input logic [`ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [`ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic crystal_input_pin,
  input logic system_wake_enable,
  input logic pin0_wave_enable,
  input logic pin1_wave_enable,
  output logic irq,
  output logic wake_request,
  output logic square_wave_out,
  output logic square_wave_pin0,
  output logic square_wave_pin1,
  output logic xtal_osc_enable
);
  localparam int RW = $clog2(READY_CYCLES + 1);
  localparam int BW = $clog2(BUSY_CYCLES + 1);

  // Busy must span at least two cycles so software can see it after a write
  if (READY_CYCLES < 1 || BUSY_CYCLES < 2) begin : g_check
    $error("rtc: ready or busy cycle count too small");
  end

  logic aw_held, w_held, do_write, upd_q;
  logic [`ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data, wmask, wd, ctrl_word;
  logic [3:0] wr_strb;
  logic [32:0] wr_cur, rd_cur;
  logic sel_sec, sel_ssec, sel_day, sel_reload, sel_ctrl, sel_trim, sel_osc;
  logic trim_ok, busy, sub_tick, sec_tick, day_hit, interval_hit, vbat_hit;
  logic osc_level, raw_4k, next_wave;
  logic [31:0] seconds, snap_sec, interval_reload, interval_count;
  logic [`SSEC_W-1:0] subsec, snap_ssec;
  logic [`DAY_W-1:0] day_alarm;
  logic write_unlock, async_read_enable, square_out_enable, ready_irq_enable;
  logic interval_alarm_flag, day_alarm_flag, counters_readable;
  logic interval_alarm_enable, day_alarm_enable, counter_enable;
  freq_sel_type out_freq_select;
  logic [`TRIM_W-1:0] trim;
  logic [23:0] vbat_time_counter;
  logic [4:0] vbat_div;
  logic raw_osc_out_enable, bypass;
  logic [3:0] osc_reserved;
  logic [RW-1:0] ready_left;
  logic [BW-1:0] busy_left;
  sync_state_type sync_state;

  rtc_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .crystal_input_pin(crystal_input_pin),
    .run(counter_enable),
    .trim(trim),
    .osc_level(osc_level),
    .raw_4k(raw_4k),
    .sub_tick(sub_tick)
  );

  assign busy = (sync_state == SYNC_WAIT);
  assign ctrl_word = {16'h0, write_unlock, async_read_enable, 3'h0, out_freq_select,
                      square_out_enable, interval_alarm_flag, day_alarm_flag,
                      ready_irq_enable, counters_readable, busy,
                      interval_alarm_enable, day_alarm_enable, counter_enable};

  // Register view; top bit marks a mapped address
  function automatic logic [32:0] reg_word(input logic [`ADDR_W-1:0] a, input logic use_snap);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    case (a)
      `OFF_SEC: r[31:0] = use_snap ? snap_sec : seconds;
      `OFF_SSEC: r[`SSEC_W-1:0] = use_snap ? snap_ssec : subsec;
      `OFF_DAY: r[`DAY_W-1:0] = day_alarm;
      `OFF_RELOAD: r[31:0] = interval_reload;
      `OFF_CTRL: r[31:0] = ctrl_word;
      `OFF_TRIM: r[31:0] = {vbat_time_counter, trim};
      `OFF_OSC: r[5:0] = {raw_osc_out_enable, bypass, osc_reserved};
      default: r[32] = 1'b0;
    endcase
    return r;
  endfunction

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_cur[32] ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte lanes merge into the current register value
  for (genvar i = 0; i < 4; i++) begin : g_mask
    assign wmask[8*i +: 8] = {8{wr_strb[i]}};
  end

  assign wr_cur = reg_word(wr_addr, 1'b0);
  assign wd = (wr_cur[31:0] & ~wmask) | (wr_data & wmask);
  assign sel_sec = do_write && wr_addr == `OFF_SEC;
  assign sel_ssec = do_write && wr_addr == `OFF_SSEC;
  assign sel_day = do_write && wr_addr == `OFF_DAY;
  assign sel_reload = do_write && wr_addr == `OFF_RELOAD;
  assign sel_ctrl = do_write && wr_addr == `OFF_CTRL;
  assign sel_trim = do_write && wr_addr == `OFF_TRIM;
  assign sel_osc = do_write && wr_addr == `OFF_OSC;
  assign trim_ok = sel_trim && write_unlock;

  // Read channel; synchronised mode serves the post-update snapshot
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_cur = reg_word(s_axi_araddr, !async_read_enable);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_cur[31:0];
      s_axi_rresp <= rd_cur[32] ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Time counters; a software write wins over the count
  assign sec_tick = sub_tick && subsec == `SSEC_MAX;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seconds <= 32'h0;
      subsec <= '0;
    end else begin
      if (sel_ssec) begin
        subsec <= wd[`SSEC_W-1:0];
      end else if (sub_tick) begin
        subsec <= subsec + 12'h1;
      end
      if (sel_sec) begin
        seconds <= wd;
      end else if (sec_tick) begin
        seconds <= seconds + 32'h1;
      end
    end
  end

  // Snapshot taken the cycle after counters settle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upd_q <= 1'b0;
      snap_sec <= 32'h0;
      snap_ssec <= '0;
    end else begin
      upd_q <= sub_tick || sel_sec || sel_ssec;
      if (upd_q) begin
        snap_sec <= seconds;
        snap_ssec <= subsec;
      end
    end
  end

  // Alarm settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      day_alarm <= '0;
      interval_reload <= 32'h0;
    end else begin
      if (sel_day) begin
        day_alarm <= wd[`DAY_W-1:0];
      end
      if (sel_reload) begin
        interval_reload <= wd;
      end
    end
  end

  // Control bits; sync-sensitive ones wait out busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_unlock <= 1'b0;
      square_out_enable <= 1'b0;
      ready_irq_enable <= 1'b0;
      async_read_enable <= 1'b0;
      out_freq_select <= FREQ_1HZ;
      interval_alarm_enable <= 1'b0;
      day_alarm_enable <= 1'b0;
      counter_enable <= 1'b0;
    end else if (sel_ctrl) begin
      write_unlock <= wd[`B_UNLOCK];
      square_out_enable <= wd[`B_SQE];
      ready_irq_enable <= wd[`B_RDYE];
      if (!busy) begin
        async_read_enable <= wd[`B_ASYNC];
        out_freq_select <= freq_sel_type'(wd[`B_FT_HI:`B_FT_LO]);
        interval_alarm_enable <= wd[`B_IEN];
        day_alarm_enable <= wd[`B_DEN];
        if (write_unlock) begin
          counter_enable <= wd[`B_RUN];
        end
      end
    end
  end

  // Alarm events
  assign day_hit = sec_tick && (seconds[`DAY_W-1:0] + 20'h1) == day_alarm;
  assign interval_hit = interval_alarm_enable && sub_tick && (&interval_count);

  // Interval counter sits at reload until enabled, then auto-reloads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interval_count <= 32'h0;
    end else if (!interval_alarm_enable) begin
      interval_count <= interval_reload;
    end else if (sub_tick) begin
      interval_count <= interval_hit ? interval_reload : interval_count + 32'h1;
    end
  end

  // Sticky flags; a hardware set beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      day_alarm_flag <= 1'b0;
      interval_alarm_flag <= 1'b0;
    end else begin
      if (day_hit) begin
        day_alarm_flag <= 1'b1;
      end else if (sel_ctrl && !busy) begin
        day_alarm_flag <= wd[`B_DFLAG];
      end
      if (interval_hit) begin
        interval_alarm_flag <= 1'b1;
      end else if (sel_ctrl && !busy) begin
        interval_alarm_flag <= wd[`B_IFLAG];
      end
    end
  end

  // Read window after each update; writing one has no effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counters_readable <= 1'b0;
      ready_left <= '0;
    end else if (sub_tick) begin
      counters_readable <= 1'b1;
      ready_left <= RW'(READY_CYCLES);
    end else begin
      if (ready_left != '0) begin
        ready_left <= ready_left - 1'b1;
      end
      if (ready_left == RW'(1) || (sel_ctrl && !wd[`B_RDY])) begin
        counters_readable <= 1'b0;
      end
    end
  end

  // Busy covers the crossing into the slow time base
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_state <= SYNC_IDLE;
      busy_left <= '0;
    end else if (sel_sec || sel_ssec || trim_ok) begin
      sync_state <= SYNC_WAIT;
      busy_left <= BW'(BUSY_CYCLES);
    end else begin
      case (sync_state)
        SYNC_IDLE: busy_left <= '0;
        SYNC_WAIT: begin
          if (busy_left == BW'(1)) begin
            sync_state <= SYNC_IDLE;
          end
          busy_left <= busy_left - 1'b1;
        end
        default: sync_state <= SYNC_IDLE;
      endcase
    end
  end

  // Trim and elapsed-time counter; every 32 seconds of running
  assign vbat_hit = sec_tick && vbat_div == `VBAT_DIV_MAX;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim <= '0;
      vbat_time_counter <= 24'h0;
      vbat_div <= 5'h0;
    end else begin
      if (sec_tick) begin
        vbat_div <= vbat_div + 5'h1;
      end
      if (trim_ok) begin
        trim <= wd[`TRIM_W-1:0];
        vbat_time_counter <= wd[31:`TRIM_W];
      end else if (vbat_hit) begin
        vbat_time_counter <= vbat_time_counter + 24'h1;
      end
    end
  end

  // Oscillator control also needs the unlock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_osc_out_enable <= 1'b0;
      bypass <= 1'b0;
      osc_reserved <= `OSC_RESET;
    end else if (sel_osc && write_unlock) begin
      raw_osc_out_enable <= wd[`B_RAW_OUT];
      bypass <= wd[`B_BYPASS];
    end
  end

  // Counter bits give 50% duty: bit 11 is 1Hz, bit 2 is 512Hz
  always_comb begin
    next_wave = 1'b0;
    if (raw_osc_out_enable) begin
      next_wave = osc_level;
    end else if (square_out_enable) begin
      case (out_freq_select)
        FREQ_1HZ: next_wave = subsec[`SSEC_W-1];
        FREQ_512HZ: next_wave = subsec[2];
        default: next_wave = raw_4k;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      wake_request <= 1'b0;
      square_wave_out <= 1'b0;
      square_wave_pin0 <= 1'b0;
      square_wave_pin1 <= 1'b0;
      xtal_osc_enable <= 1'b0;
    end else begin
      irq <= (day_alarm_flag && day_alarm_enable) || (interval_alarm_flag && interval_alarm_enable)
             || (counters_readable && ready_irq_enable);
      wake_request <= system_wake_enable && (day_alarm_flag || interval_alarm_flag);
      square_wave_out <= next_wave;
      square_wave_pin0 <= next_wave && pin0_wave_enable;
      square_wave_pin1 <= next_wave && pin1_wave_enable;
      xtal_osc_enable <= !bypass;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_counter_write;
    sel_sec || sel_ssec;
  endsequence

  a_irq_day: assert property (day_alarm_flag && day_alarm_enable |=> irq)
    else $error("irq missing for day alarm");
  a_wake_gate: assert property (wake_request |-> $past(system_wake_enable))
    else $error("wake without system enable");
  a_raw_out: assert property (raw_osc_out_enable |=> square_wave_out == $past(osc_level))
    else $error("raw oscillator not on output");
  a_freq_1hz: assert property (square_out_enable && !raw_osc_out_enable && out_freq_select == FREQ_1HZ
    |=> square_wave_out == $past(subsec[`SSEC_W-1]))
    else $error("1Hz output wrong");
  a_unlock_gate: assert property (sel_trim && !write_unlock |=> $stable(trim))
    else $error("locked trim write took effect");
  a_busy_set: assert property (s_counter_write |=> busy ##1 busy)
    else $error("busy not held after counter write");
  a_busy_block: assert property (busy && sel_ctrl |=> $stable(day_alarm_enable) && $stable(out_freq_select))
    else $error("blocked control bit changed while busy");
  a_ready_set: assert property (sub_tick |=> counters_readable)
    else $error("ready not set after update");
  a_sec_step: assert property (sec_tick && !sel_sec |=> seconds == $past(seconds) + 32'h1)
    else $error("seconds did not step on wrap");
  a_day_flag: assert property (day_hit && !sel_sec && !sel_day
    |=> day_alarm_flag && seconds[`DAY_W-1:0] == day_alarm)
    else $error("day alarm flag not set");
  a_interval_reload: assert property (interval_hit |=> interval_alarm_flag
    && interval_count == $past(interval_reload))
    else $error("interval alarm did not fire and reload");
  a_stop_hold: assert property (!counter_enable && !sel_ssec |=> $stable(subsec))
    else $error("sub-second moved while stopped");
  a_vbat_step: assert property (vbat_hit && !trim_ok |=> vbat_time_counter == $past(vbat_time_counter) + 24'h1)
    else $error("elapsed counter did not step");
  a_flag_sticky: assert property (day_alarm_flag && !sel_ctrl |=> day_alarm_flag)
    else $error("day flag dropped without write");
endmodule

// *** tb/xtal_source.sv ***
`timescale 1ns/100ps
module xtal_source #(
  parameter int HALF_NS = 125
) (
  output logic wave
);
  // Free-running like a real crystal, but sped up so a sub-second tick takes 80 cycles
  initial begin
    wave = 1'b0;
    forever #(HALF_NS) wave = ~wave;
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`include "rtc_consts.svh"
module testbench;
  localparam int HALF = 125;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [`ADDR_W-1:0] awaddr = 8'h00;
  logic [`ADDR_W-1:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp, resp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic wake_en = 1'b1, pin0_en = 1'b1, pin1_en = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, wake, sq, sq0, sq1, xen, pin;
  int err_total = 0;
  int checks = 0;

  always #12.5 aclk = ~aclk;

  // Short ready hold and a longer busy so a read can still see busy after a write
  rtc_alarm_squarewave_trim #(.READY_CYCLES(20), .BUSY_CYCLES(8)) rtc_alarm_squarewave_trim_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .crystal_input_pin(pin),
    .system_wake_enable(wake_en), .pin0_wave_enable(pin0_en), .pin1_wave_enable(pin1_en),
    .irq(irq), .wake_request(wake), .square_wave_out(sq), .square_wave_pin0(sq0),
    .square_wave_pin1(sq1), .xtal_osc_enable(xen));

  xtal_source #(.HALF_NS(HALF)) xtal_source_i (.wave(pin));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic stuck;
    err_total++;
    print_verdict;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask

  // Both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
    if (n == 50) stuck;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
    if (n == 50) stuck;
  endtask

  task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(s, e, v & m);
  endtask

  // Poll busy low; a sync that never ends is a hang
  task automatic wait_idle;
    logic [31:0] v;
    int n;
    for (n = 0; n < 40; n++) begin
      rd(`OFF_CTRL, v);
      if (v[3] === 1'b0) return;
    end
    stuck;
  endtask

  task automatic t_reset;
    logic [31:0] v;
    for (int a = 0; a <= 'h14; a += 4) rdchk("reset value", 8'(a), 32'hffffffef, 32'h0);
    rdchk("osc reset", `OFF_OSC, 32'hffffffff, 32'h9);
    chk("osc enable", 1, xen);
    rd(8'h1c, v);
    chk("unmapped read", 2, resp);
    wr(8'h1c, 32'h1);
    chk("unmapped write", 2, resp);
    $display("reset test done");
  endtask

  task automatic t_lock;
    wr(`OFF_CTRL, 32'h1);
    rdchk("locked enable", `OFF_CTRL, 32'h1, 32'h0);
    wr(`OFF_TRIM, 32'h5);
    rdchk("locked trim", `OFF_TRIM, 32'hff, 32'h0);
    wr(`OFF_CTRL, 32'h8000);
    wr(`OFF_OSC, 32'h19);
    chk("bypass", 0, xen);
    wr(`OFF_OSC, 32'h9);
    $display("lock test done");
  endtask

  task automatic t_alarm;
    int n;
    wr(`OFF_DAY, 32'h7);
    wr(`OFF_RELOAD, 32'hfffffffd);
    wr(`OFF_SEC, 32'h6);
    rdchk("busy", `OFF_CTRL, 32'h8, 32'h8);
    wait_idle;
    wr(`OFF_SSEC, 32'hffe);
    wait_idle;
    wr(`OFF_CTRL, 32'h8003);
    repeat (250) @(posedge aclk);
    rdchk("seconds", `OFF_SEC, 32'hffffffff, 32'h7);
    rdchk("day flag", `OFF_CTRL, 32'h40, 32'h40);
    chk("irq day", 1, irq);
    chk("wake day", 1, wake);
    wake_en <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("wake gated", 0, wake);
    wake_en <= 1'b1;
    wr(`OFF_CTRL, 32'h8041);
    chk("irq gated", 0, irq);
    chk("wake held", 1, wake);
    wr(`OFF_CTRL, 32'h8005);
    chk("wake cleared", 0, wake);
    repeat (330) @(posedge aclk);
    rdchk("interval flag", `OFF_CTRL, 32'hc0, 32'h80);
    chk("irq interval", 1, irq);
    wr(`OFF_CTRL, 32'h8021);
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge aclk);
    chk("irq ready", 1, irq);
    wr(`OFF_CTRL, 32'h8001);
    $display("alarm test done");
  endtask

  task automatic wave_count(input int cyc, output int e, output int h, output int p, output int q);
    logic ps, p0;
    ps = sq;
    p0 = sq0;
    e = 0;
    h = 0;
    p = 0;
    q = 0;
    repeat (cyc) begin
      @(posedge aclk);
      e += int'(sq && !ps);
      p += int'(sq0 && !p0);
      q += int'(sq1);
      h += int'(sq);
      ps = sq;
      p0 = sq0;
    end
  endtask

  // Edge counts over a window; raw pin must win over the 1Hz choice
  task automatic t_wave;
    logic [31:0] ctl [4] = '{32'h8501, 32'h8701, 32'h8301, 32'h8101};
    logic [31:0] osc [4] = '{32'h9, 32'h9, 32'h9, 32'h29};
    int cyc [4] = '{800, 800, 1280, 800};
    int div [4] = '{8, 8, 64, 1};
    int e, h, p, q, x;
    for (int i = 0; i < 4; i++) begin
      pin1_en <= (i == 2);
      wr(`OFF_OSC, osc[i]);
      wr(`OFF_CTRL, ctl[i]);
      repeat (200) @(posedge aclk);
      wave_count(cyc[i], e, h, p, q);
      x = cyc[i] * 25 / (2 * HALF * div[i]);
      chk("edges", 1, 32'(e >= x - 1 && e <= x + 1));
      chk("duty", 1, 32'(h >= cyc[i] * 7 / 16 && h <= cyc[i] * 9 / 16));
      chk("pin0 edges", 32'(e), 32'(p));
      chk("pin1 level", i == 2 ? 32'(h) : 32'h0, 32'(q));
    end
    pin1_en <= 1'b0;
    wr(`OFF_OSC, 32'h9);
    // Compensated 1Hz follows the sub-second top bit; start just below the half second
    wr(`OFF_SSEC, 32'h7fe);
    wait_idle;
    chk("1Hz low", 0, sq);
    repeat (200) @(posedge aclk);
    chk("1Hz high", 1, sq);
    $display("wave test done");
  endtask

  task automatic t_freeze;
    logic [31:0] a;
    int n;
    // Calibration order: fresh ready window, idle, unlocked trim write, idle, relock
    a = 32'h0;
    wr(`OFF_CTRL, 32'h8001);
    for (n = 0; n < 100 && a[4] !== 1'b1; n++) rd(`OFF_CTRL, a);
    chk("ready window", 1, a[4]);
    wait_idle;
    wr(`OFF_TRIM, 32'h81);
    rdchk("trim busy", `OFF_CTRL, 32'h8, 32'h8);
    wait_idle;
    rdchk("trim value", `OFF_TRIM, 32'hff, 32'h81);
    wr(`OFF_CTRL, 32'h1);
    wr(`OFF_TRIM, 32'h5);
    rdchk("relocked trim", `OFF_TRIM, 32'hff, 32'h81);
    wr(`OFF_CTRL, 32'h8001);
    wr(`OFF_CTRL, 32'h8000);
    wait_idle;
    rd(`OFF_SSEC, a);
    repeat (300) @(posedge aclk);
    rdchk("frozen subsec", `OFF_SSEC, 32'hffffffff, a);
    wr(`OFF_SEC, 32'h0);
    wr(`OFF_CTRL, 32'h8003);
    wait_idle;
    rdchk("blocked enables", `OFF_CTRL, 32'h3, 32'h0);
    $display("freeze test done");
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_lock;
    t_alarm;
    t_wave;
    t_freeze;
    print_verdict;
  end
endmodule
